// file: rtl/xmd_alu.sv
// Purpose: combinational result and flag unit
// Assumes: operands stable during the issuing cycle
// Notes: flags out are full vector; unaffected bits pass through
`include "xmd_params.svh"
module xmd_alu #(
    parameter int WIDTH = 8
) (
    input wire xmd_pkg::xmd_op_t op, // operation
    input wire logic [WIDTH-1:0] acc, // accumulator
    input wire logic [WIDTH-1:0] opnd, // memory operand
    input wire logic [2:0] bit_sel, // bit index
    input wire logic [5:0] flags_in, // current flags
    output logic [WIDTH-1:0] result, // computed byte
    output logic [5:0] flags_out, // new flags
    output logic skip // skip condition
);
    initial begin
        if (WIDTH != 8) $error("xmd_alu serves 8-bit data only");
    end

    logic c_in;
    logic [WIDTH:0] diff;
    logic [4:0] lo_diff;
    logic borrow_in;

    always_comb begin
        c_in = flags_in[`XMD_FLAG_C];
        result = opnd;
        flags_out = flags_in;
        skip = 1'b0;
        borrow_in = (op == xmd_pkg::XMD_SUB_BORROW) ? ~c_in : 1'b0;
        diff = {1'b0, acc} - {1'b0, opnd} - {{WIDTH{1'b0}}, borrow_in};
        lo_diff = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, borrow_in};
        case (op)
            xmd_pkg::XMD_ROT_LEFT: result = {opnd[6:0], opnd[7]};
            xmd_pkg::XMD_ROT_LEFT_CARRY: begin
                result = {opnd[6:0], c_in};
                flags_out[`XMD_FLAG_C] = opnd[7];
            end
            xmd_pkg::XMD_ROT_RIGHT: result = {opnd[0], opnd[7:1]};
            xmd_pkg::XMD_ROT_RIGHT_CARRY: begin
                result = {c_in, opnd[7:1]};
                flags_out[`XMD_FLAG_C] = opnd[0];
            end
            xmd_pkg::XMD_SUB_BORROW, xmd_pkg::XMD_SUB: begin
                result = diff[7:0];
                // carry is not-borrow: cleared on negative result
                flags_out[`XMD_FLAG_C] = ~diff[8];
                flags_out[`XMD_FLAG_AC] = ~lo_diff[4];
                flags_out[`XMD_FLAG_Z] = (diff[7:0] == 8'h00);
                flags_out[`XMD_FLAG_OV] = (acc[7] ^ opnd[7]) & (acc[7] ^ diff[7]);
                flags_out[`XMD_FLAG_SC] = diff[7] ^ ((acc[7] ^ opnd[7]) & (acc[7] ^ diff[7]));
                // combined zero chains with the previous Z flag across a two-byte subtract
                flags_out[`XMD_FLAG_CZ] = (op == xmd_pkg::XMD_SUB_BORROW) ?
                    ((diff[7:0] == 8'h00) & flags_in[`XMD_FLAG_Z]) : (diff[7:0] == 8'h00);
            end
            xmd_pkg::XMD_DEC_SKIP_ZERO: begin
                result = opnd - 8'h01;
                skip = (result == 8'h00);
            end
            xmd_pkg::XMD_INC_SKIP_ZERO: begin
                result = opnd + 8'h01;
                skip = (result == 8'h00);
            end
            xmd_pkg::XMD_SET_BYTE: result = `XMD_ALL_ONES;
            xmd_pkg::XMD_SET_BIT: result = opnd | (8'h01 << bit_sel);
            xmd_pkg::XMD_SKIP_NONZERO: skip = (opnd != 8'h00);
            xmd_pkg::XMD_SKIP_BIT_SET: skip = opnd[bit_sel];
            xmd_pkg::XMD_NIBBLE_SWAP: result = {opnd[3:0], opnd[7:4]};
            xmd_pkg::XMD_SKIP_ZERO: skip = (opnd == 8'h00);
            default: result = opnd;
        endcase
    end
endmodule // xmd_alu

// file: rtl/xmd_datapath.sv
// Purpose: extended memory-operation execution datapath
// Assumes: issue is one cycle per instruction; memory is read combinationally outside
// Notes: full address carries the section, so any section is reachable
`include "xmd_params.svh"
module xmd_datapath #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic clock, // instruction clock
    input wire logic rst, // async reset, active high
    input wire logic issue, // execute op this cycle
    input wire xmd_pkg::xmd_op_t op, // decoded operation
    input wire logic to_acc, // result to accumulator variant
    input wire logic [ADDR_WIDTH-1:0] mem_addr, // full operand address
    input wire logic [2:0] bit_sel, // bit index for bit ops
    input wire logic [7:0] mem_rdata, // operand byte read
    output logic [ADDR_WIDTH-1:0] mem_waddr, // write address
    output logic [7:0] mem_wdata, // write data
    output logic mem_we, // write strobe
    output logic [7:0] acc, // accumulator
    output logic [5:0] flags, // c ac z ov sc cz
    output logic skip_dummy, // dummy cycle in progress
    output logic busy // not ready for issue
);
    initial begin
        if (ADDR_WIDTH < 8 || ADDR_WIDTH > 16) $error("xmd_datapath address width out of range");
    end

    logic [7:0] alu_result;
    logic [5:0] alu_flags;
    logic alu_skip;
    logic [7:0] acc_reg, acc_next;
    logic [5:0] flags_reg, flags_next;
    logic [ADDR_WIDTH-1:0] waddr_reg, waddr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic we_reg, we_next;
    xmd_pkg::xmd_state_t state_reg, state_next;

    function automatic logic is_skip_op(input xmd_pkg::xmd_op_t o);
        is_skip_op = (o == xmd_pkg::XMD_DEC_SKIP_ZERO) || (o == xmd_pkg::XMD_INC_SKIP_ZERO) ||
            (o == xmd_pkg::XMD_SKIP_NONZERO) || (o == xmd_pkg::XMD_SKIP_BIT_SET) ||
            (o == xmd_pkg::XMD_SKIP_ZERO);
    endfunction

    // pure tests write nothing; sets always write; other accumulator variants never do
    function automatic logic writes_mem(input xmd_pkg::xmd_op_t o, input logic a);
        writes_mem = (!a || (o == xmd_pkg::XMD_SET_BYTE) || (o == xmd_pkg::XMD_SET_BIT)) &&
            (o != xmd_pkg::XMD_NOP) && (o != xmd_pkg::XMD_SKIP_NONZERO) &&
            (o != xmd_pkg::XMD_SKIP_BIT_SET) && (o != xmd_pkg::XMD_SKIP_ZERO);
    endfunction

    xmd_alu #(.WIDTH(8)) u_alu (
        .op(op),
        .acc(acc_reg),
        .opnd(mem_rdata),
        .bit_sel(bit_sel),
        .flags_in(flags_reg),
        .result(alu_result),
        .flags_out(alu_flags),
        .skip(alu_skip)
    );

    logic exec;
    assign exec = issue && (state_reg == xmd_pkg::XMD_ST_EXEC);

    always_comb begin
        acc_next = acc_reg;
        flags_next = flags_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        we_next = 1'b0;
        state_next = xmd_pkg::XMD_ST_EXEC;
        case (state_reg)
            xmd_pkg::XMD_ST_EXEC: begin
                if (exec) begin
                    flags_next = alu_flags;
                    if (writes_mem(op, to_acc)) begin
                        we_next = 1'b1;
                        waddr_next = mem_addr;
                        wdata_next = alu_result;
                    end
                    if (to_acc && writes_mem(op, 1'b0) && !writes_mem(op, 1'b1)) begin
                        acc_next = alu_result;
                    end
                    if (is_skip_op(op) && alu_skip) begin
                        state_next = xmd_pkg::XMD_ST_DUMMY;
                    end
                end
            end
            xmd_pkg::XMD_ST_DUMMY: state_next = xmd_pkg::XMD_ST_EXEC;
            default: state_next = xmd_pkg::XMD_ST_EXEC;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_reg <= `XMD_ACC_RST;
            flags_reg <= `XMD_FLAGS_RST;
            waddr_reg <= '0;
            wdata_reg <= 8'h00;
            we_reg <= 1'b0;
            state_reg <= xmd_pkg::XMD_ST_EXEC;
        end else begin
            acc_reg <= acc_next;
            flags_reg <= flags_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            we_reg <= we_next;
            state_reg <= state_next;
        end
    end

    always_comb begin
        acc = acc_reg;
        flags = flags_reg;
        mem_waddr = waddr_reg;
        mem_wdata = wdata_reg;
        mem_we = we_reg;
        skip_dummy = (state_reg == xmd_pkg::XMD_ST_DUMMY);
        busy = (state_reg == xmd_pkg::XMD_ST_DUMMY);
    end

    // helper copies of the issuing cycle for the checks below
    logic [7:0] p_opnd;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) p_opnd <= 8'h00;
        else p_opnd <= mem_rdata;
    end

    sequence issue_s(xmd_pkg::xmd_op_t o);
        exec && op == o;
    endsequence

    rot_left_mem_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_ROT_LEFT) ##0 !to_acc |=> mem_we &&
        mem_wdata == {p_opnd[6:0], p_opnd[7]} && $stable(flags))
        else $error("rotate left result wrong");
    rot_carry_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_ROT_LEFT_CARRY) |=> flags[`XMD_FLAG_C] == p_opnd[7] &&
        flags[5:1] == $past(flags[5:1]))
        else $error("rotate through carry flag wrong");
    rot_right_acc_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_ROT_RIGHT) ##0 to_acc |=> !mem_we &&
        acc == {p_opnd[0], p_opnd[7:1]})
        else $error("rotate right to accumulator wrong");
    sub_carry_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_SUB) ##0 acc_reg < mem_rdata |=> !flags[`XMD_FLAG_C])
        else $error("subtract carry not cleared on negative");
    sub_acc_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_SUB) ##0 to_acc |=> acc == $past(acc_reg) - p_opnd)
        else $error("subtract result wrong");
    skip_dummy_a: assert property (@(posedge clock) disable iff (rst)
        exec && is_skip_op(op) && alu_skip |=> skip_dummy ##1 !skip_dummy)
        else $error("skip dummy cycle wrong");
    dec_skip_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_DEC_SKIP_ZERO) ##0 !to_acc && mem_rdata == 8'h01 |=>
        mem_we && mem_wdata == 8'h00 && skip_dummy)
        else $error("decrement skip wrong");
    set_byte_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_SET_BYTE) ##0 !to_acc |=> mem_we &&
        mem_wdata == `XMD_ALL_ONES && $stable(flags))
        else $error("set byte wrong");
    test_no_write_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_SKIP_NONZERO) |=> !mem_we && skip_dummy == (p_opnd != 8'h00))
        else $error("non-zero test wrong");
    zero_test_a: assert property (@(posedge clock) disable iff (rst)
        issue_s(xmd_pkg::XMD_SKIP_ZERO) |=> skip_dummy == (p_opnd == 8'h00))
        else $error("zero test wrong");
endmodule // xmd_datapath

// file: rtl/xmd_params.svh
// Purpose: constants for the extended memory-operation datapath
// Assumes: 8-bit data, 20 MHz instruction clock
// Notes: flag bit positions are those of the flag vector ports
`ifndef XMD_PARAMS_SVH
`define XMD_PARAMS_SVH
`define XMD_FLAG_C 0
`define XMD_FLAG_AC 1
`define XMD_FLAG_Z 2
`define XMD_FLAG_OV 3
`define XMD_FLAG_SC 4
`define XMD_FLAG_CZ 5
`define XMD_ACC_RST 8'h00
`define XMD_FLAGS_RST 6'h00
`define XMD_ALL_ONES 8'hff
`define XMD_SKIP_CYCLES 2
`endif

// file: rtl/xmd_pkg.sv
// Purpose: types for the extended memory-operation datapath
// Assumes: opcode is decoded upstream into this operation code
// Notes: none
package xmd_pkg;
    typedef enum logic [4:0] {
        XMD_NOP = 5'h00,
        XMD_ROT_LEFT = 5'h01,
        XMD_ROT_LEFT_CARRY = 5'h02,
        XMD_ROT_RIGHT = 5'h03,
        XMD_ROT_RIGHT_CARRY = 5'h04,
        XMD_SUB_BORROW = 5'h05,
        XMD_SUB = 5'h06,
        XMD_DEC_SKIP_ZERO = 5'h07,
        XMD_INC_SKIP_ZERO = 5'h08,
        XMD_SET_BYTE = 5'h09,
        XMD_SET_BIT = 5'h0a,
        XMD_SKIP_NONZERO = 5'h0b,
        XMD_SKIP_BIT_SET = 5'h0c,
        XMD_NIBBLE_SWAP = 5'h0d,
        XMD_SKIP_ZERO = 5'h0e
    } xmd_op_t;
    typedef enum logic [0:0] {
        XMD_ST_EXEC = 1'b0,
        XMD_ST_DUMMY = 1'b1
    } xmd_state_t;
endpackage

// file: verif/extended_mem_op_datapath_tb.sv
// Purpose: self-checking bench for the extended memory-operation datapath
// Assumes: inputs driven at falling edges, outputs read one falling edge after issue
// Notes: flags expected as {cz, sc, ov, z, ac, c}, the port's bit order
module extended_mem_op_datapath_tb;
timeunit 1ns;
timeprecision 1ns;
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
typedef struct packed {
    logic [4:0] o; logic ta; logic [2:0] bs; logic [7:0] rd; logic [7:0] res;
    logic wr; logic skp; logic c;
} xmd_case_t;
typedef struct packed {logic [4:0] o; logic ta; logic [7:0] a; logic [7:0] m;} xmd_sub_t;
logic clock = 0, rst = 1, issue = 0, to_acc = 0;
xmd_pkg::xmd_op_t op = xmd_pkg::XMD_NOP;
logic [11:0] mem_addr = 12'h000, mem_waddr, ad;
logic [2:0] bit_sel = 3'h0;
logic [7:0] mem_rdata = 8'h00, mem_wdata, acc, ea = 8'h00;
logic mem_we, skip_dummy, busy;
logic [5:0] flags, ef = 6'h00;
int errors = 0, comparisons = 0;
// rotates, swap and set first, then skips; rotate-through-carry chains the carry
xmd_case_t cases[24] = '{
    '{5'h01,1,0,8'h96,8'h2d,1,0,0}, '{5'h01,0,0,8'h96,8'h2d,1,0,0},
    '{5'h03,1,0,8'h96,8'h4b,1,0,0}, '{5'h03,0,0,8'h96,8'h4b,1,0,0},
    '{5'h02,1,0,8'h96,8'h2c,1,0,1}, '{5'h02,0,0,8'h96,8'h2d,1,0,1},
    '{5'h04,1,0,8'h96,8'hcb,1,0,0}, '{5'h04,0,0,8'h97,8'h4b,1,0,1},
    '{5'h0d,1,0,8'h3c,8'hc3,1,0,1}, '{5'h0d,0,0,8'h3c,8'hc3,1,0,1},
    '{5'h09,0,0,8'h12,8'hff,1,0,1}, '{5'h0a,0,5,8'h01,8'h21,1,0,1},
    '{5'h07,0,0,8'h01,8'h00,1,1,1}, '{5'h07,0,0,8'h05,8'h04,1,0,1},
    '{5'h07,1,0,8'h01,8'h00,1,1,1}, '{5'h08,0,0,8'hff,8'h00,1,1,1},
    '{5'h08,1,0,8'h41,8'h42,1,0,1}, '{5'h0b,0,0,8'h10,8'h00,0,1,1},
    '{5'h0b,0,0,8'h00,8'h00,0,0,1}, '{5'h0c,0,3,8'h08,8'h00,0,1,1},
    '{5'h0c,0,3,8'hf7,8'h00,0,0,1}, '{5'h0e,0,0,8'h00,8'h00,0,1,1},
    '{5'h0e,0,0,8'h01,8'h00,0,0,1}, '{5'h08,1,0,8'hff,8'h00,1,1,1}};
xmd_sub_t subs[5] = '{'{5'h06,1,8'h05,8'h07}, '{5'h05,1,8'h10,8'h0f},
    '{5'h05,0,8'h00,8'h00}, '{5'h06,0,8'h80,8'h01}, '{5'h06,1,8'h07,8'h07}};

always #25 clock = ~clock;

xmd_datapath #(.ADDR_WIDTH(12)) dut (.clock(clock), .rst(rst), .issue(issue), .op(op),
    .to_acc(to_acc), .mem_addr(mem_addr), .bit_sel(bit_sel), .mem_rdata(mem_rdata),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_we(mem_we), .acc(acc),
    .flags(flags), .skip_dummy(skip_dummy), .busy(busy));

// a taken skip is followed at once by an issue that must be refused
task automatic run(input logic [4:0] o, input logic ta, input logic [2:0] bs,
    input logic [7:0] rd, input logic sk);
    @(negedge clock);
    op = xmd_pkg::xmd_op_t'(o);
    to_acc = ta;
    bit_sel = bs;
    mem_rdata = rd;
    mem_addr = ad;
    issue = 1'b1;
    @(negedge clock);
    issue = sk;
    if (sk) op = xmd_pkg::XMD_SET_BYTE;
endtask

task automatic chk(input logic ta, input logic wr, input logic skp, input logic [7:0] res);
    `CHK(mem_we, wr & ~ta)
    if (wr & ~ta) begin
        `CHK(mem_wdata, res)
        `CHK(mem_waddr, ad)
    end
    if (wr & ta) ea = res;
    `CHK(acc, ea)
    `CHK(flags, ef)
    `CHK(skip_dummy, skp)
    `CHK(busy, skp)
    if (skp) begin
        @(negedge clock);
        issue = 1'b0;
        `CHK(mem_we, 1'b0)
        `CHK(busy, 1'b0)
    end
endtask

task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask

// whole run needs under 10 us; 100 us means a hang
initial begin
    #100000;
    errors++;
    give_verdict();
end

initial begin
    logic [8:0] d;
    logic [4:0] h;
    logic b, z, ov;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    `CHK({acc, flags, busy, mem_we}, 16'h0000)
    for (int i = 0; i < 24; i++) begin
        ad = {i[3:0], 8'hc5};
        ef = {5'h00, cases[i].c};
        run(cases[i].o, cases[i].ta, cases[i].bs, cases[i].rd, cases[i].skp);
        chk(cases[i].ta, cases[i].wr, cases[i].skp, cases[i].res);
    end
    for (int i = 0; i < 5; i++) begin
        ad = {4'(i + 3), 8'h3a};
        run(5'h03, 1, 0, {subs[i].a[6:0], subs[i].a[7]}, 0);
        chk(1, 1, 0, subs[i].a);
        // borrow-in is the inverted carry only for the with-borrow form
        b = (subs[i].o == 5'h05) & ~ef[0];
        d = {1'b0, subs[i].a} - {1'b0, subs[i].m} - b;
        h = {1'b0, subs[i].a[3:0]} - {1'b0, subs[i].m[3:0]} - b;
        z = (d[7:0] == 8'h00);
        ov = (subs[i].a[7] ^ subs[i].m[7]) & (d[7] ^ subs[i].a[7]);
        ef = {(subs[i].o == 5'h05) ? z & ef[2] : z, d[7] ^ ov, ov, z, ~h[4], ~d[8]};
        run(subs[i].o, subs[i].ta, 0, subs[i].m, 0);
        chk(subs[i].ta, 1, 0, d[7:0]);
    end
    give_verdict();
end
endmodule // extended_mem_op_datapath_tb
